//--- acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// Register offsets (byte addresses on the register port)
`define ACS_CTRL_OFS 8'h00
`define ACS_STATUS_OFS 8'h04
`define ACS_INTERVAL_OFS 8'h08
// Slot tables: index n sits at base + 4*n
`define ACS_REG_TBL_PAGE 2'h1
`define ACS_ALT_TBL_PAGE 2'h2

// Control register fields
`define ACS_F_COUNT 3:0
`define ACS_F_FLEN 5:4
`define ACS_F_BME 6
`define ACS_F_ALTREQ 7
`define ACS_F_MOD 9:8
`define ACS_F_CHOP 11:10
`define ACS_F_DIFF 15:12
`define ACS_F_INCHOP 16

// Reset values
`define ACS_CTRL_RST 32'h0000_0007
`define ACS_INTERVAL_RST 8'h02
`define ACS_SEL_RST 4'h0

// Slot limits and special signal numbers
`define ACS_SLOT_MAX 4'ha
`define ACS_SIG_BATTERY 4'hb

// Chopper modes
`define ACS_CHOP_AUTO 2'h0
`define ACS_CHOP_POS 2'h1
`define ACS_CHOP_REV 2'h2
`define ACS_CHOP_TOGGLE 2'h3

// Filter timing in engine cycles and result widths
`define ACS_MOD_WIDE 2'h1
`define ACS_CYC_N0 10'h08a
`define ACS_CYC_N1 10'h120
`define ACS_CYC_N2 10'h180
`define ACS_CYC_W0 10'h0ba
`define ACS_CYC_W1 10'h180
`define ACS_CYC_W2 10'h24c
`define ACS_RES_N0 5'h12
`define ACS_RES_N1 5'h15
`define ACS_RES_N2 5'h16
`define ACS_RES_W0 5'h13
`define ACS_RES_W1 5'h16
`define ACS_RES_W2 5'h18

// Result alignment inside the RAM word
`define ACS_RESULT_SHIFT 8

`endif

//--- acs_pkg.sv
package acs_pkg;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      ACS_ST_SLOT = 2'b01,
      ACS_ST_SYNC = 2'b10
   } acs_state_e;

   // Signal number carried by a slot entry
   typedef logic [3:0] acs_sig_t;

endpackage

//--- acs_sync.sv
`timescale 1ns/100ps

// Three-stage pin synchroniser with a filtered level and rising-edge pulse
module acs_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous pin
   input wire logic pin_in,
   // Synchronous result
   output logic rise
);

   logic s1;
   logic s2;
   logic s3;
   logic level;

   // First stage feeds only the second one
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change is accepted only once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end

   assign rise = s2 & s3 & ~level;

endmodule // acs_sync

//--- acs_filt.sv
`timescale 1ns/100ps
`include "acs_defs.svh"

// Filter length and modulator choice to engine cycles and result width
module acs_filt (
   // Settings
   input wire logic [1:0] flen,
   input wire logic [1:0] mod_sel,
   // Derived figures
   output logic [9:0] cycles,
   output logic [4:0] res_bits
);

   wire wide = (mod_sel == `ACS_MOD_WIDE);

   // Length 3 is not defined, so it behaves as the longest filter
   assign cycles = (flen == 2'h0) ? (wide ? `ACS_CYC_W0 : `ACS_CYC_N0) :
                   (flen == 2'h1) ? (wide ? `ACS_CYC_W1 : `ACS_CYC_N1) :
                   (wide ? `ACS_CYC_W2 : `ACS_CYC_N2);
   assign res_bits = (flen == 2'h0) ? (wide ? `ACS_RES_W0 : `ACS_RES_N0) :
                     (flen == 2'h1) ? (wide ? `ACS_RES_W1 : `ACS_RES_N1) :
                     (wide ? `ACS_RES_W2 : `ACS_RES_N2);

endmodule // acs_filt

//--- acs_top.sv
`timescale 1ns/100ps
`include "acs_defs.svh"

// Contract
// RULE1: one to ten slots, one input each
// RULE2: frame starts at first slot, steps once
// RULE3: regular table unless alternate frame
// RULE4: battery load only while enable bit set
// RULE5: one slow-tick sequencer drives everything
// RULE6: request edge gives one alternate frame
// RULE7: entry n selects signal of slot n
// RULE8: result goes to word at signal number
// RULE9: result right-aligned, shifted left eight
// RULE10: slot starts on tick, 1-3 ticks long
// RULE11: length and modulator set cycles, width
// RULE12: firmware keeps voltages in same slots
// RULE13: each current pair differential or single
// RULE14: chopped pairs swap return side each frame
// RULE15: extra tick after frame, sync high
// RULE16: sync leading edge starts engine pass
// RULE17: modes 01 low, 10 high, 11 toggle
// RULE18: mode 00 toggles, forces alternate last
// RULE19: frames repeat, request pending until used
module acs_top
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Slow tick pin
   input wire logic slow_tick_clock,
   // Converter and input multiplexer
   output logic [3:0] mux_select,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [23:0] conv_data,
   output logic [1:0] filter_length,
   output logic [9:0] fir_cycles,
   output logic [4:0] fir_resolution,
   output logic battery_load_en,
   output logic [3:0] pair_differential,
   output logic [3:0] pair_return_swap,
   output logic reference_swap,
   // Shared RAM and compute engine
   output logic frame_sync,
   output logic ce_start,
   output logic ram_we,
   output logic [7:0] ram_addr,
   output logic [31:0] ram_wdata
);

   // Clamp the programmed slot count into the legal range
   function automatic logic [3:0] slot_total(input logic [3:0] f);
      if (f == 4'h0) begin
         slot_total = 4'h1;
      end else if (f > `ACS_SLOT_MAX) begin
         slot_total = `ACS_SLOT_MAX;
      end else begin
         slot_total = f;
      end
   endfunction

   // Software-visible state
   logic [31:0] ctrl;
   logic [7:0] interval;
   acs_sig_t reg_tbl [10];
   acs_sig_t alt_tbl [10];

   // Sequencer state
   acs_state_e state;
   logic [3:0] slot_idx;
   logic [1:0] tick_cnt;
   logic alt_frame;
   logic pending;
   logic [7:0] frame_cnt;
   logic diff_swap;

   // Slow tick edge, taken through the pin synchroniser
   wire tick;

   acs_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pin_in(slow_tick_clock),
      .rise(tick)
   );

   // Filter figures for the current settings
   wire [9:0] filt_cycles;
   wire [4:0] filt_res;

   acs_filt u_filt (
      .flen(ctrl[`ACS_F_FLEN]),
      .mod_sel(ctrl[`ACS_F_MOD]),
      .cycles(filt_cycles),
      .res_bits(filt_res)
   );

   // Control field decode
   wire [1:0] flen_raw = ctrl[`ACS_F_FLEN];
   wire [1:0] flen_eff = (flen_raw == 2'h3) ? 2'h2 : flen_raw;
   wire [3:0] last_slot = slot_total(ctrl[`ACS_F_COUNT]) - 4'h1; // RULE1
   wire [1:0] chop = ctrl[`ACS_F_CHOP];
   wire battery_measure_enable = ctrl[`ACS_F_BME];
   wire in_slot = (state == ACS_ST_SLOT);
   wire in_sync = (state == ACS_ST_SYNC);

   // Slot and frame boundaries, all paced by the slow tick
   // Compare by magnitude so a length lowered mid-slot ends the slot at the next tick, and a lowered count ends the frame with the current slot
   wire slot_end = in_slot & tick & (tick_cnt >= flen_eff); // RULE10
   wire frame_end = slot_end & (slot_idx >= last_slot); // RULE15
   wire frame_start = in_sync & tick; // RULE5
   wire slot_next = slot_end & ~frame_end; // RULE2
   wire start_now = frame_start | slot_next;
   wire [3:0] start_idx = frame_start ? 4'h0 : slot_idx + 4'h1; // RULE2

   // Accumulation interval position; a zero interval acts as one frame
   wire [7:0] int_last = (interval == 8'h00) ? 8'h00 : interval - 8'h01;
   wire [7:0] next_fidx = (frame_cnt >= int_last) ? 8'h00 : frame_cnt + 8'h01;
   wire forced_next = (chop == `ACS_CHOP_AUTO) & (next_fidx == int_last); // RULE18
   wire take_alt = pending | forced_next; // RULE19

   // Table lookup for the slot about to start
   wire next_alt = frame_start ? take_alt : alt_frame;
   wire [3:0] sel_reg = reg_tbl[start_idx]; // RULE7
   wire [3:0] sel_alt = alt_tbl[start_idx]; // RULE7
   wire [3:0] start_sel = next_alt ? sel_alt : sel_reg; // RULE3

   // Reference swap value loaded as the sync cycle begins
   wire swap_toggle = ~reference_swap;
   wire swap_auto = forced_next ? reference_swap : swap_toggle; // RULE18
   wire next_swap = (chop == `ACS_CHOP_POS) ? 1'b0 : // RULE17
                    (chop == `ACS_CHOP_REV) ? 1'b1 : // RULE17
                    (chop == `ACS_CHOP_TOGGLE) ? swap_toggle : swap_auto; // RULE17

   // Register port decode
   wire [3:0] tbl_idx = reg_addr[5:2];
   wire tbl_ok = (tbl_idx < `ACS_SLOT_MAX) & (reg_addr[1:0] == 2'h0);
   wire hit_reg_tbl = (reg_addr[7:6] == `ACS_REG_TBL_PAGE) & tbl_ok;
   wire hit_alt_tbl = (reg_addr[7:6] == `ACS_ALT_TBL_PAGE) & tbl_ok;
   wire hit_ctrl = (reg_addr == `ACS_CTRL_OFS);
   wire hit_status = (reg_addr == `ACS_STATUS_OFS);
   wire hit_interval = (reg_addr == `ACS_INTERVAL_OFS);
   wire ctrl_wr = reg_wr & hit_ctrl;

   // Only a low-to-high change of the request bit counts
   wire alt_edge = ctrl_wr & reg_wdata[`ACS_F_ALTREQ] & ~ctrl[`ACS_F_ALTREQ]; // RULE6

   // Read data selection; unmapped addresses read zero
   wire [31:0] status_word = {16'h0000, frame_cnt, reference_swap, pending, alt_frame, in_sync, slot_idx};
   wire [31:0] rd_val = hit_ctrl ? ctrl :
                        hit_status ? status_word :
                        hit_interval ? {24'h000000, interval} :
                        hit_reg_tbl ? {28'h0000000, reg_tbl[tbl_idx]} :
                        hit_alt_tbl ? {28'h0000000, alt_tbl[tbl_idx]} : 32'h0000_0000;

   // Result alignment: keep the valid low bits, then move up eight places
   wire [23:0] res_mask = ~(24'hff_ffff << filt_res);
   wire [23:0] result = conv_data & res_mask; // RULE9
   wire battery_blocked = (mux_select == `ACS_SIG_BATTERY) & ~battery_load_en; // RULE4

   // Control and configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= `ACS_CTRL_RST;
         interval <= `ACS_INTERVAL_RST;
      end else begin
         if (ctrl_wr) begin
            ctrl <= reg_wdata;
         end
         if (reg_wr & hit_interval) begin
            interval <= reg_wdata[7:0];
         end
      end
   end

   // Slot tables, written one entry per access
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 10; i++) begin
            reg_tbl[i] <= `ACS_SEL_RST;
            alt_tbl[i] <= `ACS_SEL_RST;
         end
      end else if (reg_wr) begin
         if (hit_reg_tbl) begin
            reg_tbl[tbl_idx] <= reg_wdata[3:0];
         end
         if (hit_alt_tbl) begin
            alt_tbl[tbl_idx] <= reg_wdata[3:0];
         end
      end
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
      end
   end

   // Pending request: a new edge wins over consumption in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pending <= 1'b0;
      end else if (alt_edge) begin
         pending <= 1'b1; // RULE6
      end else if (frame_start & take_alt) begin
         pending <= 1'b0; // RULE19
      end
   end

   // Frame state: slots back to back, then one sync tick
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ACS_ST_SYNC;
         frame_sync <= 1'b0;
         alt_frame <= 1'b0;
         frame_cnt <= 8'h00;
      end else if (frame_start) begin
         state <= ACS_ST_SLOT; // RULE19
         frame_sync <= 1'b0;
         alt_frame <= take_alt; // RULE6
         frame_cnt <= next_fidx;
      end else if (frame_end) begin
         state <= ACS_ST_SYNC;
         frame_sync <= 1'b1; // RULE15
      end
   end

   // Slot position and tick count within the slot
   always_ff @(posedge clk) begin
      if (rst) begin
         slot_idx <= 4'h0;
         tick_cnt <= 2'h0;
         mux_select <= 4'h0;
      end else if (start_now) begin
         slot_idx <= start_idx;
         tick_cnt <= 2'h0;
         mux_select <= start_sel; // RULE1
      end else if (in_slot & tick) begin
         tick_cnt <= tick_cnt + 2'h1; // RULE10
      end
   end

   // Reference and input chopping change only as the sync tick begins
   always_ff @(posedge clk) begin
      if (rst) begin
         reference_swap <= 1'b0;
         diff_swap <= 1'b0;
      end else if (frame_end) begin
         reference_swap <= next_swap; // RULE15
         diff_swap <= ~diff_swap; // RULE14
      end
   end

   // Launch pulses: converter per slot, engine on sync leading edge
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_start <= 1'b0;
         ce_start <= 1'b0;
      end else begin
         conv_start <= start_now; // RULE5
         ce_start <= frame_end; // RULE16
      end
   end

   // Result write; the multiplexer choice still names the slot's signal
   always_ff @(posedge clk) begin
      if (rst) begin
         ram_we <= 1'b0;
         ram_addr <= 8'h00;
         ram_wdata <= 32'h0000_0000;
      end else begin
         ram_we <= conv_done & ~battery_blocked; // RULE4
         ram_addr <= {4'h0, mux_select}; // RULE8
         ram_wdata <= {result, 8'h00}; // RULE9
      end
   end

   // Settings and the per-frame pair return swap mirrored to the analog side
   always_ff @(posedge clk) begin
      if (rst) begin
         filter_length <= 2'h0;
         fir_cycles <= 10'h000;
         fir_resolution <= 5'h00;
         battery_load_en <= 1'b0;
         pair_differential <= 4'h0;
         pair_return_swap <= 4'h0;
      end else begin
         filter_length <= flen_eff; // RULE10
         fir_cycles <= filt_cycles; // RULE11
         fir_resolution <= filt_res; // RULE11
         battery_load_en <= battery_measure_enable; // RULE4
         pair_differential <= ctrl[`ACS_F_DIFF]; // RULE13
         pair_return_swap <= ctrl[`ACS_F_DIFF] & {4{ctrl[`ACS_F_INCHOP] & diff_swap}}; // RULE14
      end
   end

endmodule // acs_top

//--- acs_far_model.sv
`timescale 1ns/100ps

// Converter and shared RAM on the far side of the sequencer
module acs_far_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Converter
   input wire logic slow,
   input wire logic conv_start,
   input wire logic [3:0] mux_select,
   output logic conv_done,
   output logic [23:0] conv_data,
   // Shared RAM write port
   input wire logic ram_we,
   input wire logic [7:0] ram_addr,
   input wire logic [31:0] ram_wdata
);
   logic [31:0] mem [0:255];
   logic [3:0] sig;
   int cnt;

   // Answer after 5 or 30 cycles; data churns when idle so stale values never match
   always_ff @(posedge clk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (rst) begin
         conv_data <= 24'h0;
         cnt <= 0;
      end else if (conv_start) begin
         sig <= mux_select;
         cnt <= slow ? 30 : 5;
      end else if (cnt == 1) begin
         conv_done <= 1'b1;
         conv_data <= 24'hfa5c30 | {20'h0, sig};
         cnt <= 0;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end

   // Result words land at the written address
   always_ff @(posedge clk) begin
      if (ram_we) mem[ram_addr] <= ram_wdata;
   end
endmodule // acs_far_model

//--- acs_chk.sv
`timescale 1ns/100ps

// Port-level checks of slot stepping, result writes and engine launch
module acs_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Converter side
   input wire logic [3:0] mux_select,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [23:0] conv_data,
   input wire logic [1:0] filter_length,
   input wire logic [9:0] fir_cycles,
   input wire logic [4:0] fir_resolution,
   input wire logic battery_load_en,
   // Engine and RAM side
   input wire logic frame_sync,
   input wire logic ce_start,
   input wire logic ram_we,
   input wire logic [7:0] ram_addr,
   input wire logic [31:0] ram_wdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Engine launch tied to the sync leading edge both ways
   pass_on_edge_a:
      assert property (ce_start |-> frame_sync && !$past(frame_sync)) else $error("engine start off sync edge");
   edge_gives_pass_a:
      assert property ($rose(frame_sync) |-> ce_start) else $error("sync edge without engine start");
   // No conversion starts in the sync tick
   sync_no_slot_a:
      assert property (frame_sync |-> !conv_start) else $error("slot started during sync");
   slot_hold_a:
      assert property (!conv_start |-> $stable(mux_select)) else $error("selection moved inside slot");
   start_pulse_a:
      assert property (conv_start |=> !conv_start) else $error("start longer than one cycle");
   // Result address follows the converted signal; battery only when enabled
   result_addr_a:
      assert property (conv_done && (mux_select != 4'hb || battery_load_en) |=>
         ram_we && ram_addr == {4'h0, $past(mux_select)}) else $error("result address wrong");
   battery_gate_a:
      assert property (conv_done && mux_select == 4'hb && !battery_load_en |=> !ram_we)
         else $error("battery written while disabled");
   result_align_a:
      assert property (ram_we |-> $past(conv_done) &&
         ram_wdata == {$past(conv_data) & ~(24'hffffff << fir_resolution), 8'h00})
         else $error("result word misaligned");
   filt_table_a:
      assert property (filter_length == 2'h2 && $stable(filter_length) |->
         (fir_resolution == 5'h16 && fir_cycles == 10'h180) || (fir_resolution == 5'h18 && fir_cycles == 10'h24c))
         else $error("filter figures wrong");
endmodule // acs_chk

bind acs_top acs_chk u_chk (.clk(clk), .rst(rst), .mux_select(mux_select), .conv_start(conv_start),
   .conv_done(conv_done), .conv_data(conv_data), .filter_length(filter_length), .fir_cycles(fir_cycles),
   .fir_resolution(fir_resolution), .battery_load_en(battery_load_en), .frame_sync(frame_sync),
   .ce_start(ce_start), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata));

//--- tb.sv
`timescale 1ns/100ps

// Register-driven scenarios for the slot sequencer
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic slow_tick_clock = 1'b0;
   logic slow_conv = 1'b0;
   logic [31:0] reg_rdata, ram_wdata;
   logic [3:0] mux_select, pair_differential, pair_return_swap;
   logic conv_start, conv_done, battery_load_en, reference_swap, frame_sync, ce_start, ram_we;
   logic [23:0] conv_data;
   logic [1:0] filter_length;
   logic [9:0] fir_cycles;
   logic [4:0] fir_resolution;
   logic [7:0] ram_addr;
   logic [4:0] p;
   logic [3:0] log_q[$];
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int tick_cnt = 0;
   int t;

   always #10 clk = ~clk;

   // Slow tick every 40 cycles, far faster than the real pin to keep the run short
   always @(posedge clk) begin
      tick_cnt <= (tick_cnt == 39) ? 0 : tick_cnt + 1;
      slow_tick_clock <= (tick_cnt < 20);
   end

   // Log selections at each start; 4'hf marks a frame end
   always @(posedge clk) begin
      if (!rst && conv_start === 1'b1) log_q.push_back(mux_select);
      if (!rst && ce_start === 1'b1) log_q.push_back(4'hf);
   end

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   acs_top DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_tick_clock(slow_tick_clock), .mux_select(mux_select),
      .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .filter_length(filter_length),
      .fir_cycles(fir_cycles), .fir_resolution(fir_resolution), .battery_load_en(battery_load_en),
      .pair_differential(pair_differential), .pair_return_swap(pair_return_swap),
      .reference_swap(reference_swap), .frame_sync(frame_sync), .ce_start(ce_start), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata));
   acs_far_model u_far (.clk(clk), .rst(rst), .slow(slow_conv), .conv_start(conv_start),
      .mux_select(mux_select), .conv_done(conv_done), .conv_data(conv_data), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Write then one idle cycle, so strobes never meet in one time step
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge clk);
   endtask

   task wait_ce;
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ce_start !== 1'b1 && i < 3000);
      // One more edge so the frame-end mark is logged and the next drive lands on an edge
      @(posedge clk);
   endtask

   // Skip to a frame end, then log n whole frames
   task frames(input int n, input logic [3:0] e[$]);
      wait_ce();
      log_q = {};
      repeat (n) wait_ce();
      chk(log_q.size(), e.size());
      foreach (e[i]) chk(log_q[i], e[i]);
   endtask

   function automatic logic [31:0] word(input logic [3:0] s, input logic [23:0] mask);
      return {(24'hfa5c30 | {20'h0, s}) & mask, 8'h00};
   endfunction

   task complete_run;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, then table index 10 is outside the map
      rd(8'h00, 32'h7);
      rd(8'h08, 32'h2);
      wr(8'h68, 32'h5);
      rd(8'h68, 32'h0);
      rd(8'h0c, 32'h0);
      wr(8'h44, 32'h1);
      wr(8'h48, 32'h2);
      wr(8'h80, 32'ha);
      wr(8'h84, 32'h1);
      wr(8'h88, 32'hb);
      rd(8'h88, 32'hb);
      // Three slots, battery on, toggling reference, pairs 0 and 2 differential and chopped
      wr(8'h00, 32'h0001_5c43);
      frames(2, '{4'h0, 4'h1, 4'h2, 4'hf, 4'h0, 4'h1, 4'h2, 4'hf});
      chk(pair_differential, 4'h5);
      chk(battery_load_en, 1'b1);
      chk(fir_cycles, 10'h08a);
      chk(fir_resolution, 5'h12);
      chk(u_far.mem[1], word(4'h1, 24'h03ffff));
      repeat (60) @(posedge clk);
      p = {reference_swap, pair_return_swap};
      wait_ce();
      repeat (60) @(posedge clk);
      chk(p ^ {reference_swap, pair_return_swap}, 5'h15);
      // One-cycle alternate request in mid-frame, reference held high
      @(posedge clk iff conv_start === 1'b1);
      wr(8'h00, 32'h0000_08c3);
      wr(8'h00, 32'h0000_0843);
      frames(2, '{4'ha, 4'h1, 4'hb, 4'hf, 4'h0, 4'h1, 4'h2, 4'hf});
      chk(reference_swap, 1'b1);
      chk(u_far.mem[10], word(4'ha, 24'h03ffff));
      chk(u_far.mem[11], word(4'hb, 24'h03ffff));
      // Alternate frame with the battery switched off, one frame per interval
      wr(8'h08, 32'h1);
      @(posedge clk iff conv_start === 1'b1);
      wr(8'h00, 32'h0000_0483);
      wr(8'h00, 32'h0000_0403);
      frames(1, '{4'ha, 4'h1, 4'hb, 4'hf});
      rd(8'h04, 32'h0000_0032);
      chk(battery_load_en, 1'b0);
      // One slot of three ticks, wide modulator, slow converter
      slow_conv <= 1'b1;
      wr(8'h00, 32'h0000_0520);
      frames(2, '{4'h0, 4'hf, 4'h0, 4'hf});
      chk(filter_length, 2'h2);
      chk(fir_cycles, 10'h24c);
      chk(fir_resolution, 5'h18);
      chk(reference_swap, 1'b0);
      chk(u_far.mem[0], word(4'h0, 24'hffffff));
      t = cycles;
      wait_ce();
      chk(cycles - t, 160);
      // Slot count above ten is held at ten
      slow_conv <= 1'b0;
      wr(8'h00, 32'h0000_040f);
      frames(1, '{4'h0, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hf});
      // Automatic chopping with a one-frame interval forces every frame alternate, never toggling
      wr(8'h00, 32'h0000_0043);
      frames(2, '{4'ha, 4'h1, 4'hb, 4'hf, 4'ha, 4'h1, 4'hb, 4'hf});
      chk(reference_swap, 1'b0);
      complete_run();
   end
endmodule // tb
